// [logic/sfc_pkg.sv]
// Constants, types and timing of the serial flash configuration port
package sfc_pkg;
	// ==========================================================
	// Clock rates
	localparam int MCLK_HZ = 200_000_000;
	localparam int RATE0_HZ = 12_500_000;
	localparam int RATE1_HZ = 25_000_000;
	localparam int RATE2_HZ = 50_000_000;
	localparam int RATE3_HZ = 100_000_000;
	localparam int DIV_W = 8;
	localparam logic [1:0] RATE_DEFAULT = 2'h0;
	// Half periods of the serial clock in mclk cycles
	localparam logic [DIV_W-1:0] HALF0 = DIV_W'(MCLK_HZ / (2 * RATE0_HZ));
	localparam logic [DIV_W-1:0] HALF1 = DIV_W'(MCLK_HZ / (2 * RATE1_HZ));
	localparam logic [DIV_W-1:0] HALF2 = DIV_W'(MCLK_HZ / (2 * RATE2_HZ));
	localparam logic [DIV_W-1:0] HALF3 = DIV_W'(MCLK_HZ / (2 * RATE3_HZ));
	// ==========================================================
	// Flash command frame
	localparam int HDR_BITS = 32;
	localparam logic [7:0] CMD_READ_X1 = 8'h03;
	localparam logic [7:0] CMD_READ_X4 = 8'h6B;
	localparam logic [5:0] DUMMY_X1 = 6'h00;
	localparam logic [5:0] DUMMY_X4 = 6'h08;
	localparam logic [5:0] HDR_CNT = 6'h20;
	localparam logic [3:0] STEP_X1 = 4'h1;
	localparam logic [3:0] STEP_X4 = 4'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int MAX_FLASH = 3;
	localparam int FIFO_DEPTH = 32;
	localparam int LEN_W = 16;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_READ,
		ST_FLUSH
	} sfc_state_t;

	function automatic logic [DIV_W-1:0] halfCycles(input logic [1:0] sel);
		logic [DIV_W-1:0] h;
		h = HALF0;
		case (sel)
			2'h1: h = HALF1;
			2'h2: h = HALF2;
			2'h3: h = HALF3;
			default: h = HALF0;
		endcase
		return h;
	endfunction
endpackage

// [logic/sfc_stream_if.sv]
// Byte stream carrier between the port engine and its FIFO
`timescale 1ns/1ps
interface sfc_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [logic/sfc_fifo.sv]
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rstn,
	sfc_stream_if.snk wr,
	sfc_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [AW:0] count_reg, count_next;
	logic push, pop;

	// ==========================================================
	// Pointer and fill level; full and empty follow the count exactly
	assign wr.ready = (count_reg != (AW+1)'(DEPTH));
	assign rd.valid = (count_reg != '0);
	assign rd.data = mem[rdPtr_reg];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	always_comb begin
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (push) begin
			wrPtr_next = (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
		end
		if (pop) begin
			rdPtr_next = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
		end
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
	end

	// Storage carries no reset so it can map onto plain RAM
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= wr.data;
		end
	end
endmodule // sfc_fifo

// [logic/sfc_config_port.sv]
// Active serial configuration port: flash read engine, clock divider, pin control
`timescale 1ns/1ps
module sfc_config_port #(
	parameter int NUM_FLASH = 3,
	parameter int DEPTH = sfc_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic configRequestLow,
	input wire logic deviceEnableLow,
	input wire logic readStart,
	input wire logic [1:0] readSelect,
	input wire logic [23:0] readAddr,
	input wire logic [sfc_pkg::LEN_W-1:0] readLen,
	input wire logic fourBitReadWidth,
	input wire logic [1:0] clockRateSel,
	input wire logic [3:0] serialReadDataIn,
	output logic configSerialClock,
	output logic configSerialClockOe,
	output logic serialCommandOut,
	output logic serialCommandOutOe,
	output logic [sfc_pkg::MAX_FLASH-1:0] flashSelectOutLow,
	output logic flashSelectOe,
	output logic busy,
	output logic readDone,
	output logic outValid,
	output logic [7:0] outData,
	input wire logic outReady
);
	// ==========================================================
	// Pin synchronisers
	logic [5:0] syncA_reg, syncB_reg;
	logic cfgReqLowS, devEnLowS, holdOff, floatPins;
	logic [3:0] dinS;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			syncA_reg <= 6'h00;
			syncB_reg <= 6'h00;
		end else begin
			syncA_reg <= {configRequestLow, deviceEnableLow, serialReadDataIn};
			syncB_reg <= syncA_reg;
		end
	end

	assign cfgReqLowS = syncB_reg[5];
	assign devEnLowS = syncB_reg[4];
	assign dinS = syncB_reg[3:0];
	// Request low resets the engine; with enable high the pins float too
	assign holdOff = !cfgReqLowS;
	assign floatPins = !cfgReqLowS && devEnLowS;

	// ==========================================================
	// Engine state
	sfc_pkg::sfc_state_t state_reg, state_next;
	logic [31:0] shift_reg, shift_next;
	logic [5:0] bitCnt_reg, bitCnt_next;
	logic [5:0] hdrEnd_reg, hdrEnd_next;
	logic [7:0] acc_reg, acc_next;
	logic [3:0] accCnt_reg, accCnt_next;
	logic [sfc_pkg::LEN_W-1:0] left_reg, left_next;
	logic pend_reg, pend_next;
	logic [7:0] pendData_reg, pendData_next;
	logic x4_reg, x4_next;
	logic [1:0] sel_reg, sel_next;
	logic [1:0] rate_reg, rate_next;
	logic sclk_reg, sclk_next;
	logic [sfc_pkg::DIV_W-1:0] div_reg, div_next;
	logic done_reg, done_next;
	logic run, tick, fall;
	logic [7:0] accNew;
	logic [3:0] accCntNew;

	sfc_stream_if #(.WIDTH(8)) fifoIn ();
	sfc_stream_if #(.WIDTH(8)) fifoOut ();

	assign fifoIn.valid = pend_reg;
	assign fifoIn.data = pendData_reg;

	// A full FIFO freezes the divider, so the flash simply sees a slower clock
	assign run = (state_reg == sfc_pkg::ST_SHIFT || state_reg == sfc_pkg::ST_READ)
		&& !(pend_reg && !fifoIn.ready);
	assign tick = run && (div_reg == '0);
	assign fall = tick && sclk_reg;

	// Next state of the read engine
	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bitCnt_next = bitCnt_reg;
		hdrEnd_next = hdrEnd_reg;
		acc_next = acc_reg;
		accCnt_next = accCnt_reg;
		left_next = left_reg;
		pend_next = pend_reg;
		pendData_next = pendData_reg;
		x4_next = x4_reg;
		sel_next = sel_reg;
		rate_next = rate_reg;
		sclk_next = sclk_reg;
		div_next = div_reg;
		done_next = 1'b0;
		accNew = x4_reg ? {acc_reg[3:0], dinS} : {acc_reg[6:0], dinS[1]};
		accCntNew = accCnt_reg + (x4_reg ? sfc_pkg::STEP_X4 : sfc_pkg::STEP_X1);
		if (pend_reg && fifoIn.ready) begin
			pend_next = 1'b0;
		end
		// Divider: the serial clock is derived here and driven out
		if (tick) begin
			div_next = sfc_pkg::halfCycles(rate_reg) - 1'b1;
			sclk_next = !sclk_reg;
		end else if (run) begin
			div_next = div_reg - 1'b1;
		end
		unique case (state_reg)
			sfc_pkg::ST_IDLE: begin
				sclk_next = 1'b0;
				if (readStart && !devEnLowS && readLen != '0
					&& 32'(readSelect) < NUM_FLASH) begin
					state_next = sfc_pkg::ST_SHIFT;
					x4_next = fourBitReadWidth;
					sel_next = readSelect;
					rate_next = clockRateSel;
					shift_next = {fourBitReadWidth ? sfc_pkg::CMD_READ_X4
						: sfc_pkg::CMD_READ_X1, readAddr};
					hdrEnd_next = sfc_pkg::HDR_CNT
						+ (fourBitReadWidth ? sfc_pkg::DUMMY_X4 : sfc_pkg::DUMMY_X1);
					bitCnt_next = '0;
					accCnt_next = '0;
					left_next = readLen;
					div_next = sfc_pkg::halfCycles(clockRateSel) - 1'b1;
				end
			end
			sfc_pkg::ST_SHIFT: begin
				if (fall) begin
					shift_next = {shift_reg[30:0], 1'b0};
					bitCnt_next = bitCnt_reg + 1'b1;
					if (bitCnt_reg + 1'b1 == hdrEnd_reg) begin
						state_next = sfc_pkg::ST_READ;
					end
				end
			end
			sfc_pkg::ST_READ: begin
				// Below the fastest rate each falling edge latches what the flash put out on the one before
				if (fall) begin
					acc_next = accNew;
					accCnt_next = accCntNew;
					if (accCntNew == sfc_pkg::BYTE_BITS) begin
						accCnt_next = '0;
						pend_next = 1'b1;
						pendData_next = accNew;
						left_next = left_reg - 1'b1;
						if (left_reg == 1) begin
							state_next = sfc_pkg::ST_FLUSH;
						end
					end
				end
			end
			sfc_pkg::ST_FLUSH: begin
				sclk_next = 1'b0;
				if (!pend_reg) begin
					state_next = sfc_pkg::ST_IDLE;
					done_next = 1'b1;
				end
			end
		endcase
		if (holdOff) begin
			state_next = sfc_pkg::ST_IDLE;
			sclk_next = 1'b0;
			pend_next = 1'b0;
			rate_next = sfc_pkg::RATE_DEFAULT;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= sfc_pkg::ST_IDLE;
			shift_reg <= '0;
			bitCnt_reg <= '0;
			hdrEnd_reg <= '0;
			acc_reg <= '0;
			accCnt_reg <= '0;
			left_reg <= '0;
			pend_reg <= 1'b0;
			pendData_reg <= '0;
			x4_reg <= 1'b0;
			sel_reg <= '0;
			rate_reg <= sfc_pkg::RATE_DEFAULT;
			sclk_reg <= 1'b0;
			div_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bitCnt_reg <= bitCnt_next;
			hdrEnd_reg <= hdrEnd_next;
			acc_reg <= acc_next;
			accCnt_reg <= accCnt_next;
			left_reg <= left_next;
			pend_reg <= pend_next;
			pendData_reg <= pendData_next;
			x4_reg <= x4_next;
			sel_reg <= sel_next;
			rate_reg <= rate_next;
			sclk_reg <= sclk_next;
			div_reg <= div_next;
			done_reg <= done_next;
		end
	end

	// ==========================================================
	// Pin registers; the outputs lag the engine by one mclk
	logic sclkO_reg, sclkO_next, cmdO_reg, cmdO_next, cmdOe_reg, cmdOe_next;
	logic oe_reg, oe_next, busy_reg, busy_next;
	logic [sfc_pkg::MAX_FLASH-1:0] selO_reg, selO_next;
	logic active;

	assign active = (state_reg == sfc_pkg::ST_SHIFT || state_reg == sfc_pkg::ST_READ);

	// One select per flash, shared clock and data lines
	genvar gi;
	generate
		for (gi = 0; gi < sfc_pkg::MAX_FLASH; gi++) begin : gSel
			assign selO_next[gi] = !(gi < NUM_FLASH && active && !holdOff
				&& sel_reg == 2'(gi));
		end
	endgenerate

	always_comb begin
		sclkO_next = sclk_reg;
		cmdO_next = shift_reg[31];
		// In four-bit reads the first data line turns round to an input
		cmdOe_next = !floatPins && !(x4_reg && state_reg == sfc_pkg::ST_READ);
		oe_next = !floatPins;
		busy_next = (state_reg != sfc_pkg::ST_IDLE);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclkO_reg <= 1'b0;
			cmdO_reg <= 1'b0;
			cmdOe_reg <= 1'b0;
			oe_reg <= 1'b0;
			busy_reg <= 1'b0;
			selO_reg <= '1;
		end else begin
			sclkO_reg <= sclkO_next;
			cmdO_reg <= cmdO_next;
			cmdOe_reg <= cmdOe_next;
			oe_reg <= oe_next;
			busy_reg <= busy_next;
			selO_reg <= selO_next;
		end
	end

	// ==========================================================
	// Read data buffer and registered output stage
	sfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) uFifo (
		.clk(mclk),
		.rstn(rstn),
		.wr(fifoIn),
		.rd(fifoOut)
	);

	logic oV_reg, oV_next;
	logic [7:0] oD_reg, oD_next;

	assign fifoOut.ready = !oV_reg || outReady;

	always_comb begin
		oV_next = oV_reg;
		oD_next = oD_reg;
		if (fifoOut.ready) begin
			oV_next = fifoOut.valid;
			if (fifoOut.valid) begin
				oD_next = fifoOut.data;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			oV_reg <= 1'b0;
			oD_reg <= '0;
		end else begin
			oV_reg <= oV_next;
			oD_reg <= oD_next;
		end
	end

	assign configSerialClock = sclkO_reg;
	assign configSerialClockOe = oe_reg;
	assign serialCommandOut = cmdO_reg;
	assign serialCommandOutOe = cmdOe_reg;
	assign flashSelectOutLow = selO_reg;
	assign flashSelectOe = oe_reg;
	assign busy = busy_reg;
	assign readDone = done_reg;
	assign outValid = oV_reg;
	assign outData = oD_reg;
endmodule // sfc_config_port

// [tb/sfc_config_port_checker.sv]
// Port assertions of the serial flash configuration port
`timescale 1ns/1ps
module sfc_config_port_checker #(
	parameter int NUM_FLASH = 3
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic configRequestLow,
	input wire logic deviceEnableLow,
	input wire logic configSerialClock,
	input wire logic configSerialClockOe,
	input wire logic serialCommandOut,
	input wire logic serialCommandOutOe,
	input wire logic [sfc_pkg::MAX_FLASH-1:0] flashSelectOutLow,
	input wire logic flashSelectOe,
	input wire logic busy,
	input wire logic readDone,
	input wire logic outValid,
	input wire logic [7:0] outData,
	input wire logic outReady
);
	// ==========
	// Pin rules; four cycles cover the input sync and pin register, five the busy lag
	localparam logic [2:0] ABSENT = 3'h7 << NUM_FLASH;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence floatReq;
		!configRequestLow && deviceEnableLow;
	endsequence
	sequence selLow;
		!(&flashSelectOutLow);
	endsequence
	AST_ABSENT: assert property ((flashSelectOutLow & ABSENT) == ABSENT)
		else $error("absent select low");
	AST_FLOAT: assert property (floatReq [*4] |-> !configSerialClockOe && !flashSelectOe)
		else $error("pins driven");
	AST_CMD_FLOAT: assert property (floatReq [*4] |-> !serialCommandOutOe)
		else $error("command driven");
	AST_ABORT: assert property ((!configRequestLow) [*5] |-> !busy && (&flashSelectOutLow))
		else $error("busy in reset");
	AST_CMD_STEADY: assert property (configSerialClock |-> $stable(serialCommandOut))
		else $error("command moved");
	AST_SEL_START: assert property ($rose(busy) |=> selLow)
		else $error("select late");
	AST_IDLE: assert property (!busy |-> !configSerialClock && (&flashSelectOutLow))
		else $error("idle pins");
	AST_DONE: assert property (readDone |-> (&flashSelectOutLow) ##1 !readDone)
		else $error("done pulse");
	AST_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outData))
		else $error("byte dropped");
endmodule // sfc_config_port_checker

// [tb/sfc_flash_model.sv]
// Behavioural model of the attached serial flashes
`timescale 1ns/1ps
module sfc_flash_model (
	input wire logic sclk,
	input wire logic [2:0] selLow,
	input wire logic cmdIn,
	output logic [3:0] dataOut
);
	// ==========
	// Frame handling
	logic [31:0] hdr;
	logic [1:0] idx;
	logic [7:0] cur;
	int cnt;
	int pos;
	bit x4;
	wire active = !(&selLow);
	initial dataOut = 4'h0;
	// New frame at the select edge; the low select names the flash
	always @(posedge active) begin
		cnt = 0;
		pos = 0;
		idx = selLow[0] ? (selLow[1] ? 2'h2 : 2'h1) : 2'h0;
	end
	// Released lines show the inverse of their last level
	always @(negedge active) dataOut <= ~dataOut;
	// Header sampled on rising clock edges
	always @(posedge sclk) if (active) begin
		if (cnt < 32) hdr = {hdr[30:0], cmdIn};
		cnt++;
	end
	// Data leaves on the falling edge and holds a full period
	always @(negedge sclk) if (active) begin
		x4 = hdr[31:24] == sfc_pkg::CMD_READ_X4;
		if (cnt >= (x4 ? 40 : 32)) begin
			cur = (hdr[7:0] + 8'(x4 ? pos / 2 : pos / 8)) ^ {idx, 6'h15};
			if (x4) dataOut <= pos[0] ? cur[3:0] : cur[7:4];
			else dataOut <= {~dataOut[3:2], cur[7 - pos % 8], ~dataOut[0]};
			pos++;
		end
	end
endmodule // sfc_flash_model

// [tb/sfc_config_port_bench.sv]
// Self-checking bench of the serial flash configuration port
`timescale 1ns/1ps
module sfc_config_port_bench;
	localparam int NF = 2;
	logic mclk, rstn, configRequestLow, deviceEnableLow, readStart, fourBitReadWidth, outReady;
	logic configSerialClock, configSerialClockOe, serialCommandOut, serialCommandOutOe;
	logic flashSelectOe, busy, readDone, outValid, hold, firstHi;
	logic [1:0] readSelect, clockRateSel, rateNow;
	logic [23:0] readAddr;
	logic [15:0] readLen;
	logic [3:0] serialReadDataIn;
	logic [2:0] flashSelectOutLow;
	logic [7:0] outData;
	logic [7:0] expQ[$];
	int num_errors = 0, checks_done = 0, seed = 4, cycles = 0, hiCnt = 0;
	// Released selects pull high, released clock low
	wire [2:0] selPin = flashSelectOe ? flashSelectOutLow : 3'h7;
	wire clkPin = configSerialClockOe & configSerialClock;
	// Released command line belongs to the programmer, which leaves it idling high
	wire cmdPin = serialCommandOutOe ? serialCommandOut : 1'b1;
	sfc_config_port #(.NUM_FLASH(NF)) i_dut (.mclk, .rstn, .configRequestLow, .deviceEnableLow,
		.readStart, .readSelect, .readAddr, .readLen, .fourBitReadWidth, .clockRateSel,
		.serialReadDataIn, .configSerialClock, .configSerialClockOe, .serialCommandOut,
		.serialCommandOutOe, .flashSelectOutLow, .flashSelectOe, .busy, .readDone, .outValid,
		.outData, .outReady);
	sfc_flash_model i_flash (.sclk(clkPin), .selLow(selPin), .cmdIn(cmdPin),
		.dataOut(serialReadDataIn));
	// ==========
	// Clock, hang limit, reader stalls
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			complete_run();
		end
		outReady <= !hold && ($random(seed) & 3) != 0;
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (exp !== got) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Byte the flash model holds at an offset from the start address
	function automatic logic [7:0] expByte(input logic [1:0] s, input logic [7:0] a, input int i);
		return (a + 8'(i)) ^ {s, 6'h15};
	endfunction
	// Accepted bytes against the queue
	always @(posedge mclk) if (rstn && outValid && outReady) begin
		if (expQ.size() == 0) check("extra byte", 16'h0, 16'h1);
		else check("byte", 16'(expQ.pop_front()), 16'(outData));
	end
	// First high phase of each read shows the chosen rate
	always @(posedge mclk) begin
		if (clkPin) hiCnt <= hiCnt + 1;
		else if (hiCnt != 0) begin
			if (firstHi) check("half period", 16'(8 >> rateNow), 16'(hiCnt));
			firstHi <= 1'b0;
			hiCnt <= 0;
		end
	end
	// One read; a nonzero cut aborts it that many cycles in
	task automatic doRead(input logic [1:0] s, input logic [23:0] a, input logic [15:0] n,
			input logic x4, input logic [1:0] r, input int cut);
		logic ok;
		ok = s < NF && n != 0 && !deviceEnableLow;
		@(posedge mclk);
		readSelect <= s;
		readAddr <= a;
		readLen <= n;
		fourBitReadWidth <= x4;
		clockRateSel <= r;
		readStart <= 1'b1;
		@(posedge mclk);
		readStart <= 1'b0;
		rateNow = r;
		firstHi = 1'b1;
		for (int i = 0; i < n && ok; i++) expQ.push_back(expByte(s, a[7:0], i));
		repeat (3) @(negedge mclk);
		check("busy", 16'(ok), 16'(busy));
		check("select", 16'(ok ? 3'(~(3'h1 << s)) : 3'h7), 16'(selPin));
		if (cut != 0) begin
			repeat (cut) @(posedge mclk);
			configRequestLow <= 1'b0;
			deviceEnableLow <= 1'b1;
			repeat (6) @(negedge mclk);
			check("floated", 16'h0, 16'({busy, configSerialClockOe, serialCommandOutOe,
				flashSelectOe}));
			repeat (200) @(posedge mclk);
			expQ.delete();
			configRequestLow <= 1'b1;
			deviceEnableLow <= 1'b0;
			repeat (6) @(posedge mclk);
		end else if (ok) begin
			for (int k = 0; k < 20000 && readDone !== 1'b1; k++) @(negedge mclk);
			check("read done", 16'h1, 16'(readDone));
			for (int k = 0; k < 20000 && expQ.size() != 0; k++) @(negedge mclk);
			check("bytes left", 16'h0, 16'(expQ.size()));
		end
	endtask
	// Main sequence
	initial begin
		{rstn, readStart, hold, outReady, firstHi, fourBitReadWidth} = 6'h00;
		{configRequestLow, deviceEnableLow} = 2'h2;
		{readSelect, clockRateSel, rateNow} = 6'h00;
		readAddr = 24'h000000;
		readLen = 16'h0000;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (8) @(posedge mclk);
		for (int i = 0; i < 6; i++) doRead(2'(i % 2), 24'hFFFFFE, 16'h3, i >= 3, 2'(i % 3), 0);
		doRead(2'h2, 24'h000100, 16'h2, 1'b0, 2'h0, 0);
		doRead(2'h0, 24'h000100, 16'h0, 1'b0, 2'h0, 0);
		deviceEnableLow <= 1'b1;
		repeat (4) @(posedge mclk);
		doRead(2'h1, 24'h000010, 16'h1, 1'b1, 2'h2, 0);
		deviceEnableLow <= 1'b0;
		repeat (4) @(posedge mclk);
		repeat (10) doRead(2'($random(seed)), 24'($random(seed)), 16'($random(seed) & 5),
			1'($random(seed)), 2'($random(seed)) % 2'h3, 0);
		doRead(2'h0, 24'h123456, 16'h6, 1'b0, 2'h1, 300);
		// Fastest rate is cut inside the header, so only its clock is judged
		doRead(2'h0, 24'h000200, 16'h2, 1'b0, 2'h3, 40);
		// Fill the buffer while the reader stalls, then drain it
		hold = 1'b1;
		fork
			doRead(2'h1, 24'h00ABCD, 16'h28, 1'b1, 2'h2, 0);
			begin
				repeat (1500) @(negedge mclk);
				check("stall", 16'h6, 16'({busy, outValid, selPin[1]}));
				hold = 1'b0;
			end
		join
		complete_run();
	end
endmodule // sfc_config_port_bench
bind sfc_config_port sfc_config_port_checker #(.NUM_FLASH(NUM_FLASH)) i_chk (.mclk, .rstn,
	.configRequestLow, .deviceEnableLow, .configSerialClock, .configSerialClockOe,
	.serialCommandOut, .serialCommandOutOe, .flashSelectOutLow, .flashSelectOe, .busy,
	.readDone, .outValid, .outData, .outReady);
